// ==== tsa_defs.svh ====
/*
 * Constants of the thermostat alarm block: register pointers, configuration
 * field positions, reset values, fault counts and conversion times.
 * Assumes it is included by bare name by every file that needs it.
 */
//
// Behaviour
// - Comparator: alarm after N readings at/above high.
// - Comparator: alarm holds until N readings below low.
// - Power-up: comparator, high 80C, low 75C.
// - Interrupt: first alarm after N readings at/above high.
// - Interrupt: alarm cleared by shutdown or register read.
// - Interrupt: next alarm from readings below low.
// - Interrupt: same limit never alarms twice running.
// - Open-drain alarm, polarity bit, active low default.
// - Pointer selects temperature, config, low, high.
// - Pointer resets to zero, otherwise keeps value.
// - Config readable, writable, MSB first, reset default.
// - Shutdown clear: convert continuously, store each result.
// - Shutdown set: finish conversion, standby, bus alive.
// - Shutdown clears interrupt alarm, keeps comparator alarm.
// - Mode bit: zero comparator, one interrupt.
// - Fault queue codes give 1, 2, 4, 6.
// - Resolution codes give 9 to 12 bits.
// - Reserved config top bit reads zero.
// - Setpoints are 12-bit two's complement, left-justified.
// - Comparator ignores setpoint bits below resolution.
// - Temperature left-justified, unused low bits zero.
// - Acknowledge control code 1001 plus select pins.
`ifndef TSA_DEFS_SVH
`define TSA_DEFS_SVH
`define TSA_PTR_TEMP 8'h00
`define TSA_PTR_CFG 8'h01
`define TSA_PTR_LOW_HYSTERESIS_SETPOINT 8'h02
`define TSA_PTR_TOS 8'h03
`define TSA_PTR_RST 8'h00
`define TSA_CTRL_CODE 4'h9
`define TSA_TOS_RST 12'h500
`define TSA_LOW_HYSTERESIS_SETPOINT_RST 12'h4B0
`define TSA_CFG_RST 7'h00
`define TSA_CFG_SD 0
`define TSA_CFG_TM 1
`define TSA_CFG_POL 2
`define TSA_CFG_FQ_LO 3
`define TSA_CFG_FQ_HI 4
`define TSA_CFG_RES_LO 5
`define TSA_CFG_RES_HI 6
`define TSA_FQ_N0 3'h1
`define TSA_FQ_N1 3'h2
`define TSA_FQ_N2 3'h4
`define TSA_FQ_N3 3'h6
`define TSA_RES_MASK 16'hFF80
`define TSA_CLK_HZ 50000000.0
`define TSA_CONV9_S 0.15
`define TSA_CONV10_S 0.3
`define TSA_CONV11_S 0.6
`define TSA_CONV12_S 1.2
`endif

// ==== tsa_pkg.sv ====
/*
 * Types of the thermostat alarm block: link states and state records.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package tsa_pkg;
	// One-hot states of the two-wire slave engine.
	typedef enum logic [5:0] {
		LK_IDLE = 6'h01,
		LK_ADDR = 6'h02,
		LK_RX = 6'h04,
		LK_ACK = 6'h08,
		LK_TX = 6'h10,
		LK_TXACK = 6'h20
	} tsa_link_t;

	// Whole state of the top module.
	typedef struct packed {
		tsa_link_t link;
		logic scl_q;
		logic sda_q;
		logic [3:0] bits;
		logic [7:0] shf;
		logic rw;
		logic [1:0] bidx;
		logic ridx;
		logic [7:0] ptr;
		logic [6:0] cfg;
		logic [11:0] low_hysteresis_setpoint;
		logic [11:0] tos;
		logic [7:0] wmsb;
		logic [11:0] temp;
		logic alarm;
		logic watch_low;
		logic [2:0] fcount;
		logic sda_oe;
		logic alarm_oe;
		logic drive_lvl;
	} tsa_top_st_t;

	// Whole state of the conversion timer.
	typedef struct packed {
		logic [26:0] cnt;
		logic busy;
		logic done;
		logic [15:0] val;
	} tsa_conv_st_t;
endpackage
`default_nettype wire

// ==== tsa_sync.sv ====
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes inputs are asynchronous to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module tsa_sync #(
	parameter int W = 5,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	// Stages and filtered output form one record.
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} tsa_sync_st_t;
	tsa_sync_st_t r_reg;
	tsa_sync_st_t r_next;

	// The output follows only when stages two and three agree.
	always_comb
	begin
		r_next = r_reg;
		r_next.s1 = i_d;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		for (int i = 0; i < W; i++)
		begin
			if (r_reg.s2[i] == r_reg.s3[i])
			begin
				r_next.q[i] = r_reg.s3[i];
			end
		end
	end

	// Synchronous reset to the idle level.
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			r_reg <= {INIT, INIT, INIT, INIT};
		end
		else if (i_ce)
		begin
			r_reg <= r_next;
		end
	end
	assign o_q = r_reg.q;
endmodule // tsa_sync
`default_nettype wire

// ==== tsa_conv.sv ====
/*
 * Conversion timer: paces conversions by resolution and captures readings.
 * Assumes i_sample is the converter's reading on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tsa_defs.svh"
module tsa_conv #(
	parameter int CYC0 = int'(`TSA_CONV9_S * `TSA_CLK_HZ),
	parameter int CYC1 = int'(`TSA_CONV10_S * `TSA_CLK_HZ),
	parameter int CYC2 = int'(`TSA_CONV11_S * `TSA_CLK_HZ),
	parameter int CYC3 = int'(`TSA_CONV12_S * `TSA_CLK_HZ)
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic [1:0] i_res,
	input wire logic i_sd,
	input wire logic [15:0] i_sample,
	output logic o_done,
	output logic [15:0] o_val
);
	tsa_pkg::tsa_conv_st_t r_reg;
	tsa_pkg::tsa_conv_st_t r_next;
	logic [26:0] lim; // First count of a conversion at this resolution.
	logic [15:0] mask; // Keeps only the selected resolution's bits.

	// Conversion length and reading mask follow the resolution bits.
	always_comb
	begin
		case (i_res)
			2'h0: lim = 27'(CYC0 - 1);
			2'h1: lim = 27'(CYC1 - 1);
			2'h2: lim = 27'(CYC2 - 1);
			default: lim = 27'(CYC3 - 1);
		endcase
		mask = 16'($signed(`TSA_RES_MASK) >>> i_res);
	end

	// Runs conversions back to back; shutdown only stops the next one.
	always_comb
	begin
		r_next = r_reg;
		r_next.done = 1'b0;
		if (r_reg.busy)
		begin
			if (r_reg.cnt == 27'h0)
			begin
				r_next.done = 1'b1;
				r_next.val = i_sample & mask;
				r_next.busy = !i_sd;
				r_next.cnt = lim;
			end
			else
			begin
				r_next.cnt = 27'(r_reg.cnt - 27'h1);
			end
		end
		else if (!i_sd)
		begin
			r_next.busy = 1'b1;
			r_next.cnt = lim;
		end
	end

	// Conversions begin right after reset.
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			r_reg <= '0;
		end
		else if (i_ce)
		begin
			r_reg <= r_next;
		end
	end
	assign o_done = r_reg.done;
	assign o_val = r_reg.val;

	// In standby no reading is ever reported.
	sd_idle_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(!r_reg.busy && i_sd && i_ce) |=> !r_reg.done)
		else $error("Reading reported while in standby.");
endmodule // tsa_conv
`default_nettype wire

// ==== tsa_top.sv ====
/*
 * Thermostat alarm block: two-wire slave, register bank, fault queue and
 * open-drain alarm pin.
 * Assumes an external wire resolves the open-drain pins from the enables,
 * and I_SAMPLE is the converter's reading on I_CLOCK.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tsa_defs.svh"
module tsa_top #(
	parameter int CONV_CYC0 = int'(`TSA_CONV9_S * `TSA_CLK_HZ),
	parameter int CONV_CYC1 = int'(`TSA_CONV10_S * `TSA_CLK_HZ),
	parameter int CONV_CYC2 = int'(`TSA_CONV11_S * `TSA_CLK_HZ),
	parameter int CONV_CYC3 = int'(`TSA_CONV12_S * `TSA_CLK_HZ)
) (
	input wire logic I_CLOCK,
	input wire logic I_RST_B,
	input wire logic I_CE,
	input wire logic I_SCL,
	input wire logic I_SDA_IN,
	output logic O_SDA_OUT,
	output logic O_SDA_OE,
	input wire logic I_SLAVE_SELECT_0,
	input wire logic I_SLAVE_SELECT_1,
	input wire logic I_SLAVE_SELECT_2,
	input wire logic [15:0] I_SAMPLE,
	output logic O_ALARM_OUT,
	output logic O_ALARM_OE
);
	// Power-up contents of the whole state record.
	localparam tsa_pkg::tsa_top_st_t RST = '{
		link: tsa_pkg::LK_IDLE,
		scl_q: 1'b1,
		sda_q: 1'b1,
		bits: 4'h0,
		shf: 8'h00,
		rw: 1'b0,
		bidx: 2'h0,
		ridx: 1'b0,
		ptr: `TSA_PTR_RST,
		cfg: `TSA_CFG_RST,
		low_hysteresis_setpoint: `TSA_LOW_HYSTERESIS_SETPOINT_RST,
		tos: `TSA_TOS_RST,
		wmsb: 8'h00,
		temp: 12'h000,
		alarm: 1'b0,
		watch_low: 1'b0,
		fcount: 3'h0,
		sda_oe: 1'b0,
		alarm_oe: 1'b0,
		drive_lvl: 1'b0
	};

	tsa_pkg::tsa_top_st_t r_reg;
	tsa_pkg::tsa_top_st_t r_next;
	logic [4:0] pins; // Filtered bus and select pins.
	logic scl_s; // Filtered bus clock.
	logic sda_s; // Filtered bus data.
	logic [2:0] sel_s; // Filtered select pins.
	logic cv_done; // One-cycle pulse per finished conversion.
	logic [15:0] cv_val; // Masked reading of that conversion.
	logic scl_rise; // Bus clock went high.
	logic scl_fall; // Bus clock went low.
	logic bus_start; // Start condition seen.
	logic bus_stop; // Stop condition seen.
	logic ptr_wr; // Pointer byte taken this cycle.
	logic rd_hit; // Read access acknowledged this cycle.
	logic sd_set; // Shutdown bit written from zero to one.
	logic [15:0] rd_word; // Register selected by the pointer.
	logic [7:0] rd_byte; // Byte of it now due out.
	logic [15:0] mask; // Resolution mask for the comparator.
	logic [15:0] hi_m; // High setpoint, masked.
	logic [15:0] lo_m; // Low setpoint, masked.
	logic ge_high; // Reading at or above the high setpoint.
	logic lt_low; // Reading below the low setpoint.
	logic viol; // Reading violates the watched limit.
	logic [2:0] need; // Consecutive violations needed.
	logic trig; // Fault queue full on this reading.

	// Bus and select pins cross into the clock domain.
	tsa_sync #(
		.W(5),
		.INIT(5'h1F)
	) u_sync (
		.i_clk(I_CLOCK),
		.i_rst_b(I_RST_B),
		.i_ce(I_CE),
		.i_d({I_SCL, I_SDA_IN, I_SLAVE_SELECT_2, I_SLAVE_SELECT_1, I_SLAVE_SELECT_0}),
		.o_q(pins)
	);
	assign scl_s = pins[4];
	assign sda_s = pins[3];
	assign sel_s = pins[2:0];

	// Conversion pacing and capture of readings.
	tsa_conv #(
		.CYC0(CONV_CYC0),
		.CYC1(CONV_CYC1),
		.CYC2(CONV_CYC2),
		.CYC3(CONV_CYC3)
	) u_conv (
		.i_clk(I_CLOCK),
		.i_rst_b(I_RST_B),
		.i_ce(I_CE),
		.i_res(r_reg.cfg[`TSA_CFG_RES_HI:`TSA_CFG_RES_LO]),
		.i_sd(r_reg.cfg[`TSA_CFG_SD]),
		.i_sample(I_SAMPLE),
		.o_done(cv_done),
		.o_val(cv_val)
	);

	// Read data: left-justified words, configuration repeated in both bytes.
	always_comb
	begin
		case (r_reg.ptr)
			`TSA_PTR_TEMP: rd_word = {r_reg.temp, 4'h0};
			`TSA_PTR_CFG: rd_word = {1'b0, r_reg.cfg, 1'b0, r_reg.cfg};
			`TSA_PTR_LOW_HYSTERESIS_SETPOINT: rd_word = {r_reg.low_hysteresis_setpoint, 4'h0};
			`TSA_PTR_TOS: rd_word = {r_reg.tos, 4'h0};
			default: rd_word = 16'h0000;
		endcase
		rd_byte = r_reg.ridx ? rd_word[7:0] : rd_word[15:8];
	end

	// Comparator: setpoints are masked to the resolution in use.
	always_comb
	begin
		mask = 16'($signed(`TSA_RES_MASK) >>> r_reg.cfg[`TSA_CFG_RES_HI:`TSA_CFG_RES_LO]);
		hi_m = {r_reg.tos, 4'h0} & mask;
		lo_m = {r_reg.low_hysteresis_setpoint, 4'h0} & mask;
		ge_high = $signed(cv_val) >= $signed(hi_m);
		lt_low = $signed(cv_val) < $signed(lo_m);
		viol = r_reg.watch_low ? lt_low : ge_high;
		case (r_reg.cfg[`TSA_CFG_FQ_HI:`TSA_CFG_FQ_LO])
			2'h0: need = `TSA_FQ_N0;
			2'h1: need = `TSA_FQ_N1;
			2'h2: need = `TSA_FQ_N2;
			default: need = `TSA_FQ_N3;
		endcase
		trig = cv_done && viol && (3'(r_reg.fcount + 3'h1) >= need);
	end

	// Bus engine, register writes and thermostat in one next-state process.
	always_comb
	begin
		r_next = r_reg;
		ptr_wr = 1'b0;
		rd_hit = 1'b0;
		sd_set = 1'b0;
		scl_rise = scl_s && !r_reg.scl_q;
		scl_fall = !scl_s && r_reg.scl_q;
		bus_start = scl_s && r_reg.scl_q && r_reg.sda_q && !sda_s;
		bus_stop = scl_s && r_reg.scl_q && !r_reg.sda_q && sda_s;
		r_next.scl_q = scl_s;
		r_next.sda_q = sda_s;
		case (r_reg.link)
			tsa_pkg::LK_IDLE:
			begin
				r_next.sda_oe = 1'b0;
			end
			tsa_pkg::LK_ADDR, tsa_pkg::LK_RX:
			begin
				if (scl_rise)
				begin
					// Bits arrive most significant first.
					r_next.shf = {r_reg.shf[6:0], sda_s};
					r_next.bits = 4'(r_reg.bits + 4'h1);
				end
				else if (scl_fall && r_reg.bits == 4'h8)
				begin
					r_next.link = tsa_pkg::LK_ACK;
					r_next.sda_oe = 1'b1;
					if (r_reg.link == tsa_pkg::LK_ADDR)
					begin
						// Only our control code and select pins are answered.
						if (r_reg.shf[7:4] == `TSA_CTRL_CODE && r_reg.shf[3:1] == sel_s)
						begin
							r_next.rw = r_reg.shf[0];
							r_next.bidx = 2'h0;
							r_next.ridx = 1'b0;
							rd_hit = r_reg.shf[0];
						end
						else
						begin
							r_next.link = tsa_pkg::LK_IDLE;
							r_next.sda_oe = 1'b0;
						end
					end
					else
					begin
						// First byte is the pointer, then data bytes.
						r_next.bidx = (r_reg.bidx == 2'h3) ? 2'h3 : 2'(r_reg.bidx + 2'h1);
						case (r_reg.bidx)
							2'h0:
							begin
								ptr_wr = 1'b1;
								r_next.ptr = r_reg.shf;
							end
							2'h1:
							begin
								r_next.wmsb = r_reg.shf;
								if (r_reg.ptr == `TSA_PTR_CFG)
								begin
									r_next.cfg = r_reg.shf[6:0];
									sd_set = r_reg.shf[`TSA_CFG_SD] && !r_reg.cfg[`TSA_CFG_SD];
								end
							end
							2'h2:
							begin
								if (r_reg.ptr == `TSA_PTR_LOW_HYSTERESIS_SETPOINT)
								begin
									r_next.low_hysteresis_setpoint = {r_reg.wmsb, r_reg.shf[7:4]};
								end
								else if (r_reg.ptr == `TSA_PTR_TOS)
								begin
									r_next.tos = {r_reg.wmsb, r_reg.shf[7:4]};
								end
							end
							default:
							begin
								r_next.bidx = 2'h3;
							end
						endcase
					end
				end
			end
			tsa_pkg::LK_ACK:
			begin
				if (scl_fall)
				begin
					// Release acknowledge, or put out the first bit of a byte.
					r_next.bits = 4'h0;
					r_next.sda_oe = 1'b0;
					r_next.link = tsa_pkg::LK_RX;
					if (r_reg.rw)
					begin
						r_next.link = tsa_pkg::LK_TX;
						r_next.shf = rd_byte;
						r_next.sda_oe = !rd_byte[7];
						r_next.ridx = !r_reg.ridx;
					end
				end
			end
			tsa_pkg::LK_TX:
			begin
				if (scl_fall)
				begin
					r_next.bits = 4'(r_reg.bits + 4'h1);
					r_next.shf = {r_reg.shf[6:0], 1'b0};
					r_next.sda_oe = !r_reg.shf[6];
					if (r_reg.bits == 4'h7)
					begin
						r_next.link = tsa_pkg::LK_TXACK;
						r_next.sda_oe = 1'b0;
					end
				end
			end
			tsa_pkg::LK_TXACK:
			begin
				// A missing master acknowledge ends the read.
				if (scl_rise)
				begin
					r_next.link = sda_s ? tsa_pkg::LK_IDLE : tsa_pkg::LK_ACK;
				end
			end
			default:
			begin
				r_next.link = tsa_pkg::LK_IDLE;
				r_next.sda_oe = 1'b0;
			end
		endcase
		if (bus_start)
		begin
			r_next.link = tsa_pkg::LK_ADDR;
			r_next.bits = 4'h0;
			r_next.sda_oe = 1'b0;
		end
		else if (bus_stop)
		begin
			r_next.link = tsa_pkg::LK_IDLE;
			r_next.sda_oe = 1'b0;
		end

		// Interrupt mode: a read or entering shutdown clears the alarm.
		if (r_reg.cfg[`TSA_CFG_TM] && (rd_hit || sd_set))
		begin
			r_next.alarm = 1'b0;
		end
		// Each reading is stored and counted against the watched limit.
		if (cv_done)
		begin
			r_next.temp = cv_val[15:4];
			r_next.fcount = viol ? 3'(r_reg.fcount + 3'h1) : 3'h0;
		end
		// A full queue flips the watched limit; the set wins over a clear.
		if (trig)
		begin
			r_next.fcount = 3'h0;
			r_next.watch_low = !r_reg.watch_low;
			if (r_reg.cfg[`TSA_CFG_TM])
			begin
				r_next.alarm = 1'b1;
			end
			else
			begin
				r_next.alarm = !r_reg.watch_low;
			end
		end
		// Open drain: pull low unless the pin's level is to be high.
		r_next.alarm_oe = r_next.alarm ^ r_next.cfg[`TSA_CFG_POL];
	end

	// Single state register with clock enable.
	always_ff @(posedge I_CLOCK)
	begin
		if (!I_RST_B)
		begin
			r_reg <= RST;
		end
		else if (I_CE)
		begin
			r_reg <= r_next;
		end
	end
	assign O_SDA_OUT = r_reg.drive_lvl;
	assign O_SDA_OE = r_reg.sda_oe;
	assign O_ALARM_OUT = r_reg.drive_lvl;
	assign O_ALARM_OE = r_reg.alarm_oe;

	alarm_pin_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		O_ALARM_OE == (r_reg.alarm ^ r_reg.cfg[`TSA_CFG_POL]))
		else $error("Alarm pin level disagrees with alarm and polarity.");
	ptr_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		$changed(r_reg.ptr) |-> $past(ptr_wr))
		else $error("Pointer changed without a pointer byte.");
	int_sd_clear_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		(I_CE && sd_set && r_reg.cfg[`TSA_CFG_TM] && !trig) |=> !r_reg.alarm)
		else $error("Shutdown did not clear the interrupt alarm.");
	cmp_sd_keep_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		(I_CE && sd_set && !r_reg.cfg[`TSA_CFG_TM] && !cv_done) |=> $stable(r_reg.alarm))
		else $error("Shutdown changed the comparator alarm.");
	read_clear_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		(I_CE && rd_hit && r_reg.cfg[`TSA_CFG_TM] && !trig) |=> !r_reg.alarm)
		else $error("Register read did not clear the interrupt alarm.");
	count_reset_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		(I_CE && cv_done && !viol) |=> r_reg.fcount == 3'h0)
		else $error("Fault count kept after a good reading.");
	cmp_raise_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		(I_CE && !r_reg.cfg[`TSA_CFG_TM] && !r_reg.watch_low && cv_done && ge_high
		&& r_reg.fcount == need - 3'h1) |=> r_reg.alarm)
		else $error("Comparator alarm not raised with a full queue.");
	cmp_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		(I_CE && !r_reg.cfg[`TSA_CFG_TM] && r_reg.alarm && r_reg.watch_low && !lt_low)
		|=> r_reg.alarm)
		else $error("Comparator alarm dropped above the low setpoint.");
	int_alt_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		(I_CE && trig) |=> (r_reg.watch_low != $past(r_reg.watch_low)) ##1 !trig)
		else $error("Watched limit did not alternate after an alarm.");
	ack_rel_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
		(r_reg.link == tsa_pkg::LK_ADDR && scl_fall && r_reg.bits == 4'h8
		&& r_reg.shf[7:4] != `TSA_CTRL_CODE && I_CE) |=> !O_SDA_OE)
		else $error("Foreign control code acknowledged.");
endmodule // tsa_top
`default_nettype wire

// ==== tsa_bus_master.sv ====
/*
 * Two-wire bus master model standing on the far side of the block.
 * Assumes the bench resolves SDA from o_sda_pull and the block's enable.
 */
`timescale 1ns/1ps
`default_nettype none
module tsa_bus_master (
	output logic o_scl,
	output logic o_sda_pull,
	input wire logic i_sda
);
	// Phase lengths in ns; high and low phases last at least five system clocks, the setup step two.
	localparam int T_HI = 100;
	localparam int T_LO = 140;
	localparam int T_SET = 40;

	// The clock stands still high and data is released between frames.
	initial
	begin
		o_scl = 1'b1;
		o_sda_pull = 1'b0;
	end

	// Start from an idle bus: data falls while the clock is high.
	task automatic do_start();
		#T_HI;
		o_sda_pull = 1'b1;
		#T_HI;
		o_scl = 1'b0;
		#T_SET;
	endtask

	// One pulse: data is set in the low phase and sampled at the end of high.
	task automatic do_bit(input logic b, output logic s);
		o_sda_pull = ~b;
		#(T_LO - T_SET);
		o_scl = 1'b1;
		#T_HI;
		s = i_sda;
		o_scl = 1'b0;
		#T_SET;
	endtask

	// Stop: data rises while the clock is high, then the bus rests.
	task automatic do_stop();
		o_sda_pull = 1'b1;
		#(T_LO - T_SET);
		o_scl = 1'b1;
		#T_HI;
		o_sda_pull = 1'b0;
		#T_HI;
	endtask

	// Sends a byte MSB first and collects the acknowledge bit.
	task automatic put_byte(input logic [7:0] v, inout logic nak);
		logic s;
		for (int i = 7; i >= 0; i--)
			do_bit(v[i], s);
		do_bit(1'b1, s);
		nak = nak | s;
	endtask

	// Receives a byte MSB first; last answers with a not-acknowledge.
	task automatic get_byte(input logic last, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--)
			do_bit(1'b1, v[i]);
		do_bit(last, s);
	endtask

	// Write frame: pointer byte first, then nb data bytes, MSB first.
	task automatic wr(input logic [2:0] sel, input logic [7:0] ptr, input logic [15:0] d,
		input int nb, output logic nak);
		nak = 1'b0;
		do_start();
		put_byte({4'h9, sel, 1'b0}, nak);
		put_byte(ptr, nak);
		if (nb > 0)
			put_byte(d[15:8], nak);
		if (nb > 1)
			put_byte(d[7:0], nak);
		do_stop();
	endtask

	// Read frame of one word; a refused address leaves the pulled-up level.
	task automatic rd(input logic [2:0] sel, output logic [15:0] d, output logic nak);
		nak = 1'b0;
		d = 16'hFFFF;
		do_start();
		put_byte({4'h9, sel, 1'b1}, nak);
		if (!nak)
		begin
			get_byte(1'b0, d[15:8]);
			get_byte(1'b1, d[7:0]);
		end
		do_stop();
	endtask
endmodule // tsa_bus_master
`default_nettype wire

// ==== tsa_top_tb_top.sv ====
/*
 * Self-checking bench of the thermostat alarm block with a bus master model.
 * Assumes pull-ups on SDA and the alarm pin, and shortened conversions.
 */
`timescale 1ns/1ps
`default_nettype none
module tsa_top_tb_top;
	// Conversion period at 9 bits with slack, in clocks.
	localparam int P = 42;
	logic clk, rst_b, scl, sda_pull, sda_oe, sda_out, alm_oe, alm_out, alarm_polarity_bit, nak;
	logic [2:0] sel;
	logic [15:0] smp, rdat;
	int num_errors = 0;
	int tests_run = 0;
	logic [15:0] exp_q[$];
	logic [15:0] obs_q[$];
	string name_q[$];
	// Open-drain wires: low while any party pulls, else pulled high.
	wire logic sda_wire = !(sda_pull || (sda_oe && !sda_out));
	wire logic alm_pin = !(alm_oe && !alm_out);

	tsa_top #(.CONV_CYC0(40), .CONV_CYC1(80), .CONV_CYC2(160), .CONV_CYC3(320)) dut (
		.I_CLOCK(clk), .I_RST_B(rst_b), .I_CE(1'b1), .I_SCL(scl), .I_SDA_IN(sda_wire),
		.O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .I_SLAVE_SELECT_0(sel[0]),
		.I_SLAVE_SELECT_1(sel[1]), .I_SLAVE_SELECT_2(sel[2]), .I_SAMPLE(smp),
		.O_ALARM_OUT(alm_out), .O_ALARM_OE(alm_oe));
	tsa_bus_master mdl (.o_scl(scl), .o_sda_pull(sda_pull), .i_sda(sda_wire));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Waits n edges, then steps just past the edge.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic note(input string nm, input logic [15:0] v);
		name_q.push_back(nm);
		exp_q.push_back(v);
	endtask
	// Reads one word; the ack and the word both go to the checker.
	task automatic rd_chk(input string nm, input logic [2:0] s, input logic [15:0] v);
		note({nm, "_ack"}, {15'h0, s != sel});
		note(nm, v);
		mdl.rd(s, rdat, nak);
		obs_q.push_back({15'h0, nak});
		obs_q.push_back(rdat);
	endtask
	task automatic wr(input logic [7:0] p, input logic [15:0] d, input int nb);
		note("wr_ack", 16'h0000);
		mdl.wr(sel, p, d, nb, nak);
		obs_q.push_back({15'h0, nak});
	endtask
	task automatic set_cfg(input logic [7:0] c);
		wr(8'h01, {c, 8'h00}, 1);
		alarm_polarity_bit = c[2];
	endtask
	// Active alarm shows the polarity level on the pin.
	task automatic al_chk(input logic act);
		note("alarm_pin", {15'h0, act ? alarm_polarity_bit : ~alarm_polarity_bit});
		obs_q.push_back({15'h0, alm_pin});
	endtask
	task automatic set_smp(input logic [15:0] v);
		@(posedge clk);
		#1;
		smp = v;
	endtask
	task automatic end_sim();
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Takes the oldest expectation whenever an observation appears.
	initial
	begin
		string nm;
		logic [15:0] e;
		logic [15:0] o;
		forever
		begin
			wait (obs_q.size() != 0);
			nm = name_q.pop_front();
			e = exp_q.pop_front();
			o = obs_q.pop_front();
			tests_run++;
			if (o !== e)
			begin
				num_errors++;
				$display("BAD %s expected %h seen %h", nm, e, o);
			end
		end
	end

	// Cuts a hang short well past the expected run length.
	initial
	begin
		#1500000;
		num_errors++;
		end_sim();
	end

	initial
	begin
		int n;
		rst_b = 1'b0;
		void'($urandom(32'h59B9797A));
		sel = 3'($urandom());
		smp = {4'h1, 12'($urandom())};
		alarm_polarity_bit = 1'b0;
		cyc(2);
		rst_b = 1'b1;
		cyc(4 * P);
		// Power-up contents and pointer behaviour.
		rd_chk("temp", sel, smp & 16'hFF80);
		al_chk(1'b0);
		wr(8'h01, 16'h0000, 0);
		rd_chk("config", sel, 16'h0000);
		wr(8'h02, 16'h0000, 0);
		rd_chk("low_set", sel, 16'h4B00);
		wr(8'h03, 16'h0000, 0);
		rd_chk("high_set", sel, 16'h5000);
		rd_chk("high_again", sel, 16'h5000);
		rd_chk("wrong_sel", sel ^ 3'h5, 16'hFFFF);
		// Reserved bit, resolution, refused places.
		set_cfg(8'hE0);
		rd_chk("config_res", sel, 16'h6060);
		wr(8'h00, 16'h7FFF, 2);
		cyc(3 * 330);
		rd_chk("temp12", sel, smp & 16'hFFF0);
		// The two middle resolutions mask the reading as well.
		set_cfg(8'h20);
		wr(8'h00, 16'h0000, 0);
		cyc(2 * 330);
		rd_chk("temp10", sel, smp & 16'hFFC0);
		set_cfg(8'h40);
		wr(8'h00, 16'h0000, 0);
		cyc(2 * 330);
		rd_chk("temp11", sel, smp & 16'hFFE0);
		wr(8'h07, 16'h0000, 0);
		rd_chk("no_reg", sel, 16'h0000);
		wr(8'h03, 16'h5074, 2);
		rd_chk("high_wr", sel, 16'h5070);
		// Comparator with every fault count; the fine setpoint bits are masked.
		for (int fq = 0; fq < 4; fq++)
		begin
			n = (fq == 0) ? 1 : 2 * fq;
			set_cfg({3'b000, 2'(fq), 1'(fq), 2'b00});
			// A slow conversion still running must end before the first reading counts.
			if (fq == 0)
				cyc(330);
			set_smp(16'h5000);
			if (n > 1)
			begin
				// Look no later than one plain conversion period per counted reading.
				cyc((n - 1) * (P - 2));
				al_chk(1'b0);
			end
			cyc(2 * P + 7);
			al_chk(1'b1);
			set_smp(16'h1000);
			cyc((n + 1) * P + 5);
			al_chk(1'b0);
		end
		// Hysteresis band and shutdown in comparator mode.
		set_smp(16'h5000);
		cyc(8 * P);
		set_smp(16'h4C00);
		cyc(8 * P);
		al_chk(1'b1);
		set_cfg(8'h1D);
		cyc(2 * P);
		set_smp(16'h1000);
		cyc(3 * P);
		al_chk(1'b1);
		wr(8'h00, 16'h0000, 0);
		rd_chk("temp_sd", sel, 16'h4C00);
		set_cfg(8'h1C);
		cyc(8 * P);
		al_chk(1'b0);
		// Interrupt mode: alternate limits, clears by read and by shutdown.
		set_cfg(8'h02);
		set_smp(16'h5800);
		cyc(3 * P);
		al_chk(1'b1);
		rd_chk("config_int", sel, 16'h0202);
		al_chk(1'b0);
		cyc(3 * P);
		al_chk(1'b0);
		set_smp(16'h4000);
		cyc(3 * P);
		al_chk(1'b1);
		set_cfg(8'h03);
		al_chk(1'b0);
		set_cfg(8'h02);
		cyc(3 * P);
		al_chk(1'b0);
		set_smp(16'h5800);
		cyc(3 * P);
		al_chk(1'b1);
		wait (obs_q.size() == 0);
		#1;
		end_sim();
	end
endmodule // tsa_top_tb_top
`default_nettype wire
